// ==== logic/l2cpc_top.sv ====
// l2 cache policy control: avalon slave registers, policy and refresh timer
`timescale 1ns/1ns
module l2cpc_top
  import l2cpc_pkg::*;
#(
  parameter int INTERVAL = REFRESH_INTERVAL
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [l2cpc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dram_cache_present,
  input wire logic populated,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic cyc_cacheable,
  input wire logic tag_match,
  input wire logic line_dirty,
  output logic hit_r,
  output logic miss_r,
  output logic invalidate_r,
  output logic writeback_r,
  output logic cacheable_indicator_n,
  output logic refresh_idle_busy
);
  import l2cpc_pkg::*;
  // each register sits alone at its offset, data in byte lane 0
  function automatic logic reg_sel(input logic [7:0] a,
      input logic [7:0] ofs);
    reg_sel = (a == ofs);
  endfunction : reg_sel
  l2cpc_cfg_if cfg();
  logic [7:0] cache_control_r;
  logic [4:0] refresh_idle_r;
  logic present_r;
  logic ctrl_sel;
  logic ext_sel;
  assign ctrl_sel = reg_sel(avs_address, CACHE_CONTROL_OFS);
  assign ext_sel = reg_sel(avs_address, EXT_CACHE_CONTROL_OFS);
  assign cfg.enable = cache_control_r[CTRL_ENABLE_BIT];
  assign cfg.force_miss = cache_control_r[CTRL_FORCE_MISS_BIT];
  assign cfg.size = cache_control_r[CTRL_SIZE_LSB +: 2];
  assign cfg.refresh_idle = refresh_idle_r;
  // strap sampled after release, not under reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      present_r <= 1'b0;
    end else begin
      present_r <= dram_cache_present;
    end
  end
  // one wait state: request taken, answered on the next edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end
  // write lands only at the edge that completes the transfer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cache_control_r <= CACHE_CONTROL_RST;
      refresh_idle_r <= REFRESH_RST;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      if (ctrl_sel) begin
        cache_control_r <= avs_writedata[7:0] & CTRL_WRITE_MASK;
      end
      if (ext_sel) begin
        // values under the minimum are stored; software must avoid them
        refresh_idle_r <= avs_writedata[4:0];
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= UNMAPPED_READ;
    end else if (avs_read && avs_waitrequest) begin
      // captured when taken so it stands at the completing edge
      if (ctrl_sel) begin
        avs_readdata <= {24'h000000, cache_control_r};
      end else if (ext_sel) begin
        avs_readdata <= {24'h000000, 2'b00, present_r,
          refresh_idle_r};
      end else begin
        avs_readdata <= UNMAPPED_READ;
      end
    end
  end
  l2cpc_policy u_policy (
    .clock(clock),
    .rst_n(rst_n),
    .cfg(cfg.user),
    .populated(populated),
    .cyc_valid(cyc_valid),
    .cyc_write(cyc_write),
    .cyc_cacheable(cyc_cacheable),
    .tag_match(tag_match),
    .line_dirty(line_dirty),
    .hit(hit_r),
    .miss(miss_r),
    .invalidate(invalidate_r),
    .writeback(writeback_r),
    .cacheable_n(cacheable_indicator_n)
  );
  l2cpc_refresh #(.INTERVAL(INTERVAL)) u_refresh (
    .clock(clock),
    .rst_n(rst_n),
    .present(present_r),
    .idle_len(refresh_idle_r),
    .busy(refresh_idle_busy)
  );
endmodule : l2cpc_top

// ==== include/l2cpc_pkg.sv ====
// package: register map, fields, reset values and timing for l2cpc
//
// Contract
// - force-miss set disables hit detection; every lookup misses when enable is set, populated and size nonzero.
// - force-miss with cache enabled takes the miss path each cycle.
// - enable clear, force-miss set, populated: reads invalidate their tag.
// - force-miss clear gives normal hit and miss detection.
// - flush by force-miss plus reading all tags; modified lines write back.
// - enable set asserts cacheable indicator on cacheable memory cycles.
// - enable clear keeps cacheable indicator negated, so no line fills.
// - enable set, force-miss clear: normal operation subject to cache size.
// - enable and force-miss set: reads and writes both forced as misses.
// - bit 5 of extended register reads 1 when a dram cache is fitted.
// - bits 4:0 set host clocks idle during each dram cache refresh.
// - extended register resets to 14h, twenty host clocks of idle.
package l2cpc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CACHE_CONTROL_OFS = 8'h52;
  localparam logic [7:0] EXT_CACHE_CONTROL_OFS = 8'h53;
  localparam logic [7:0] CACHE_CONTROL_RST = 8'h00;
  localparam logic [7:0] EXT_CACHE_CONTROL_RST = 8'h14;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_MISS_BIT = 1;
  localparam int CTRL_SIZE_LSB = 6;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hC3;
  localparam int EXT_PRESENT_BIT = 5;
  localparam int REFRESH_W = 5;
  localparam logic [4:0] REFRESH_MIN = 5'h04;
  localparam logic [4:0] REFRESH_RST = 5'h14;
  localparam int REFRESH_INTERVAL = 1560;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [2:0] {
    L2CPC_IDLE = 3'b001,
    L2CPC_HOLD = 3'b010,
    L2CPC_DONE = 3'b100
  } l2cpc_ref_t;
endpackage : l2cpc_pkg

// ==== include/l2cpc_cfg_if.sv ====
// interface: control bits passed from register file to policy logic
`timescale 1ns/1ns
interface l2cpc_cfg_if;
  logic enable;
  logic force_miss;
  logic [1:0] size;
  logic [4:0] refresh_idle;
  logic refresh_busy;
  modport regs (output enable, output force_miss, output size,
    output refresh_idle, input refresh_busy);
  modport user (input enable, input force_miss, input size,
    input refresh_idle, output refresh_busy);
endinterface : l2cpc_cfg_if

// ==== logic/l2cpc_refresh.sv ====
// refresh idle timer for a dram-type secondary cache
`timescale 1ns/1ns
module l2cpc_refresh
  import l2cpc_pkg::*;
#(
  parameter int INTERVAL = REFRESH_INTERVAL
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic present,
  input wire logic [l2cpc_pkg::REFRESH_W-1:0] idle_len,
  output logic busy
);
  import l2cpc_pkg::*;
  // hold plus done must fit inside one interval; gap counter is 16 bits
  if (INTERVAL < 32 || INTERVAL > 65535) begin : g_bad_interval
    $error("refresh interval out of range");
  end
  logic [15:0] gap_r;
  logic [4:0] idle_r;
  l2cpc_ref_t state_r;
  // interval divider gives one-cycle refresh requests
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 16'h0000;
    end else if (gap_r == 16'(INTERVAL - 1)) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= L2CPC_IDLE;
      idle_r <= 5'h00;
      busy <= 1'b0;
    end else begin
      case (state_r)
        L2CPC_IDLE: begin
          if (present && gap_r == 16'(INTERVAL - 1)) begin
            // length latched so a write mid-refresh cannot cut it short
            idle_r <= idle_len;
            busy <= 1'b1;
            state_r <= L2CPC_HOLD;
          end
        end
        L2CPC_HOLD: begin
          if (idle_r <= 5'h01) begin
            busy <= 1'b0;
            state_r <= L2CPC_DONE;
          end else begin
            idle_r <= idle_r - 5'h01;
          end
        end
        L2CPC_DONE: state_r <= L2CPC_IDLE;
        default: begin
          state_r <= L2CPC_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule : l2cpc_refresh

// ==== logic/l2cpc_policy.sv ====
// hit, miss, invalidate and cacheable decisions for one host cycle
`timescale 1ns/1ns
module l2cpc_policy
  import l2cpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  l2cpc_cfg_if.user cfg,
  input wire logic populated,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic cyc_cacheable,
  input wire logic tag_match,
  input wire logic line_dirty,
  output logic hit,
  output logic miss,
  output logic invalidate,
  output logic writeback,
  output logic cacheable_n
);
  import l2cpc_pkg::*;
  logic l2_on;
  assign l2_on = cfg.enable && populated && (cfg.size != 2'b00);
  assign cfg.refresh_busy = 1'b0;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
      miss <= 1'b0;
      invalidate <= 1'b0;
      writeback <= 1'b0;
      cacheable_n <= 1'b1;
    end else begin
      // force-miss masks the comparator so lookups never hit
      hit <= cyc_valid && l2_on && !cfg.force_miss &&
        tag_match;
      miss <= cyc_valid && l2_on &&
        (cfg.force_miss || !tag_match);
      // flush: forced miss on a read evicts a dirty line to memory
      writeback <= cyc_valid && l2_on && line_dirty &&
        (cfg.force_miss || !tag_match);
      invalidate <= cyc_valid && !cyc_write && populated &&
        !cfg.enable && cfg.force_miss;
      cacheable_n <= !(cyc_valid && cfg.enable &&
        cyc_cacheable);
    end
  end
endmodule : l2cpc_policy

// ==== dv/l2cpc_props.sv ====
// checker: timing relations on the l2cpc_top ports
`timescale 1ns/1ns
module l2cpc_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic cyc_cacheable,
  input wire logic tag_match,
  input wire logic line_dirty,
  input wire logic hit_r,
  input wire logic miss_r,
  input wire logic invalidate_r,
  input wire logic writeback_r,
  input wire logic cacheable_indicator_n,
  input wire logic refresh_idle_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // run length of busy; a five-bit idle field caps it at 31
  logic [5:0] busy_len_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_r <= 6'h00;
    end else if (refresh_idle_busy) begin
      busy_len_r <= busy_len_r + 6'h01;
    end else begin
      busy_len_r <= 6'h00;
    end
  end
  a_refresh_len_cap: assert property (busy_len_r <= 6'h1F)
    else $error("refresh idle too long");
  a_hit_miss_apart: assert property (!(hit_r && miss_r))
    else $error("hit and miss together");
  a_hit_needs_match: assert property (
    hit_r |-> $past(cyc_valid && tag_match)) else $error("hit without match");
  a_miss_has_cycle: assert property (
    miss_r |-> $past(cyc_valid)) else $error("miss without cycle");
  a_inval_on_read: assert property (
    invalidate_r |-> $past(cyc_valid && !cyc_write))
    else $error("invalidate not on read");
  a_wb_dirty_line: assert property (
    writeback_r |-> $past(cyc_valid && line_dirty))
    else $error("writeback of clean line");
  a_cacheable_flag: assert property (
    !cacheable_indicator_n |-> $past(cyc_valid && cyc_cacheable))
    else $error("cacheable on noncacheable cycle");
  a_ack_next_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_ack_one_wide: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
endmodule : l2cpc_props
bind l2cpc_top l2cpc_props u_props (.clock(clock), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cyc_valid(cyc_valid),
  .cyc_write(cyc_write), .cyc_cacheable(cyc_cacheable),
  .tag_match(tag_match), .line_dirty(line_dirty), .hit_r(hit_r),
  .miss_r(miss_r), .invalidate_r(invalidate_r), .writeback_r(writeback_r),
  .cacheable_indicator_n(cacheable_indicator_n),
  .refresh_idle_busy(refresh_idle_busy));

// ==== dv/l2cpc_host.sv ====
// host bus model: one host cycle per go pulse
`timescale 1ns/1ns
module l2cpc_host (
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] qual,
  output logic cyc_valid,
  output logic [3:0] cyc_q
);
  initial begin
    cyc_valid = 1'b0;
    cyc_q = 4'h0;
  end
  // qualifiers flip outside a cycle so stale values never pass as valid
  always @(posedge clock) begin
    cyc_valid <= go;
    cyc_q <= go ? qual : ~cyc_q;
  end
endmodule : l2cpc_host

// ==== dv/l2cpc_top_tb.sv ====
// testbench: l2 cache policy control
`timescale 1ns/1ns
module l2cpc_top_tb;
  import l2cpc_pkg::*;
  logic clock, rst_n, rd, wr, go, pres, pop, cv, wt, hit, miss, inv, wb;
  logic kn, busy;
  logic [7:0] adr;
  logic [31:0] wd, rdat, got;
  logic [3:0] q, cq;
  // force, enable, populated, qualifiers, then hit miss inv wb cacheable_n
  logic [11:0] rows [8] = '{12'h6D0, 12'h6AA, 12'hEEA, 12'hF49,
    12'hAC5, 12'hB41, 12'h2C1, 12'h4C0};
  int err_total, check_count, n;
  l2cpc_host host (.clock(clock), .go(go), .qual(q), .cyc_valid(cv),
    .cyc_q(cq));
  l2cpc_top #(.INTERVAL(32)) uut (.clock(clock), .rst_n(rst_n),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wt),
    .dram_cache_present(pres), .populated(pop), .cyc_valid(cv),
    .cyc_write(cq[3]), .cyc_cacheable(cq[2]), .tag_match(cq[1]),
    .line_dirty(cq[0]), .hit_r(hit), .miss_r(miss), .invalidate_r(inv),
    .writeback_r(wb), .cacheable_indicator_n(kn), .refresh_idle_busy(busy));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    adr <= a;
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wt !== 1'b0 && n < 20);
    got = rdat;
    if (n >= 20) begin
      err_total++;
      end_of_test();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(got, {24'h0, e});
  endtask : rchk
  task automatic cyc(input logic [3:0] qq, input logic [4:0] e);
    @(posedge clock);
    go <= 1'b1;
    q <= qq;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
    chk({27'h0, hit, miss, inv, wb, kn}, {27'h0, e});
  endtask : cyc
  task automatic refr(input int e);
    int m;
    m = 0;
    n = 0;
    while (busy !== 1'b0 && n < 99) begin
      @(posedge clock);
      n++;
    end
    while (busy !== 1'b1 && n < 99) begin
      @(posedge clock);
      n++;
    end
    while (busy === 1'b1 && m < 40) begin
      @(posedge clock);
      m++;
    end
    if (n >= 99) begin
      err_total++;
      end_of_test();
    end
    chk(m, e);
  endtask : refr
  initial begin
    {rst_n, rd, wr, go, pres, pop, adr, wd, q} = '0;
    pres = 1'b1;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rchk(CACHE_CONTROL_OFS, CACHE_CONTROL_RST);
    rchk(EXT_CACHE_CONTROL_OFS, 8'h34);
    rchk(8'h60, 8'h00);
    refr(20);
    $display("reset values done");
    foreach (rows[i]) begin
      pop <= rows[i][9];
      bus(1'b1, CACHE_CONTROL_OFS, {2'h3, 4'h0, rows[i][11:10]});
      cyc(rows[i][8:5], rows[i][4:0]);
    end
    // size zero: second level off, first level still cacheable
    pop <= 1'b1;
    bus(1'b1, CACHE_CONTROL_OFS, 8'h01);
    cyc(4'h6, 5'h00);
    $display("policy table done");
    bus(1'b1, CACHE_CONTROL_OFS, 8'hFF);
    rchk(CACHE_CONTROL_OFS, 8'hC3);
    bus(1'b1, EXT_CACHE_CONTROL_OFS, 8'hFF);
    rchk(EXT_CACHE_CONTROL_OFS, 8'h3F);
    bus(1'b1, EXT_CACHE_CONTROL_OFS, 8'h04); // smallest legal idle
    refr(4);
    rst_n <= 1'b0;
    @(posedge clock);
    chk({26'h0, wt, kn, busy, hit, miss, inv}, 32'h0000_0030);
    chk(rdat, 32'h0000_0000);
    rst_n <= 1'b1;
    rchk(CACHE_CONTROL_OFS, 8'h00);
    rchk(EXT_CACHE_CONTROL_OFS, 8'h34);
    $display("registers and refresh done");
    end_of_test();
  end
endmodule : l2cpc_top_tb
